// >>> tedc_pkg.sv
// shared constants and carriers of the timer event block
package tedc_pkg;
    // register file addresses
    localparam logic [7:0] ADDR_DMA_COUNTER_POINTER = 8'hF0;
    localparam logic [7:0] ADDR_DMA_ADDRESS_POINTER = 8'hF1;
    localparam logic [7:0] ADDR_TIMER_INTERRUPT_VECTOR = 8'hF2;
    localparam logic [7:0] ADDR_OUTPUT_B_CONTROL = 8'hFD;
    localparam logic [7:0] ADDR_TIMER_EVENT_FLAGS = 8'hFE;
    localparam logic [7:0] ADDR_INTERRUPT_DMA_MASK = 8'hFF;
    // reset values
    localparam logic [7:0] RST_OUTPUT_B_CONTROL = 8'h00;
    localparam logic [7:0] RST_TIMER_EVENT_FLAGS = 8'h00;
    localparam logic [7:0] RST_INTERRUPT_DMA_MASK = 8'h00;
    localparam logic [7:0] RST_POINTER = 8'h00;
    localparam logic [7:0] RST_VECTOR = 8'h00;
    // output_b_control field positions
    localparam int OBC_CMP0_LSB = 6;
    localparam int OBC_CMP1_LSB = 4;
    localparam int OBC_OVF_LSB = 2;
    localparam int OBC_EVENT_BIT = 1;
    localparam int OBC_PRESET_BIT = 0;
    // timer_event_flags bit positions
    localparam int FLG_CAP0 = 7;
    localparam int FLG_CAP1 = 6;
    localparam int FLG_CMP0 = 5;
    localparam int FLG_CMP1 = 4;
    localparam int FLG_OVF = 3;
    localparam int FLG_CAP0_OVR = 2;
    localparam int FLG_CMP0_OVR = 1;
    localparam int FLG_COMBINE = 0;
    // interrupt_dma_mask bit positions
    localparam int MSK_GLOBAL = 7;
    localparam int MSK_CAP0_DMA = 6;
    localparam int MSK_CAP0_IRQ = 5;
    localparam int MSK_CAP1_IRQ = 4;
    localparam int MSK_CMP0_DMA = 3;
    localparam int MSK_CMP0_IRQ = 2;
    localparam int MSK_CMP1_IRQ = 1;
    localparam int MSK_OVF_IRQ = 0;
    // pointer fields
    localparam int PTR_SWAP_BIT = 2;
    localparam int PTR_DIR_BIT = 1;
    localparam int PTR_SEL_BIT = 0;
    // vector group codes
    localparam logic [1:0] GRP_OVERFLOW = 2'h0;
    localparam logic [1:0] GRP_CAPTURE = 2'h2;
    localparam logic [1:0] GRP_COMPARE = 2'h3;

    // timer events coming from the counter datapath
    typedef struct packed {
        logic cmp0Match;
        logic cmp1Match;
        logic overUnder;
        logic capture0;
        logic capture1;
    } tedc_events_s;

    // dma controller status toward this block
    typedef struct packed {
        logic cap0Request;
        logic cmp0Request;
        logic cap0EndOfBlock;
        logic cmp0EndOfBlock;
        logic swapToggle;
    } tedc_dma_s;

    // register-file access strobe
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } tedc_regacc_s;
endpackage : tedc_pkg

// >>> tedc_outb.sv
// output-b pin action merge and on-chip event pulse
module tedc_outb
    import tedc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clkEn,
    input wire logic [7:0] ctrl,
    input wire logic presetWr,
    input wire logic presetVal,
    input wire tedc_events_s events,
    output logic pinLevel,
    output logic eventPulse
);
    // all state of the module
    typedef struct packed {
        logic pin;
        logic pulse;
    } tedc_outb_s;

    tedc_outb_s state_q;
    tedc_outb_s state_d;
    logic bit0; // merged action bit 1 (upper bit of each field)
    logic bit1; // merged action bit 0 (lower bit of each field)

    // next state: merge coinciding actions, then apply to the pin
    always_comb begin
        state_d = state_q;
        // and together fields of all coinciding events; idle events count as ones
        bit0 = (~events.cmp0Match | ctrl[OBC_CMP0_LSB+1])
            & (~events.cmp1Match | ctrl[OBC_CMP1_LSB+1])
            & (~events.overUnder | ctrl[OBC_OVF_LSB+1]); // RQ4
        bit1 = (~events.cmp0Match | ctrl[OBC_CMP0_LSB])
            & (~events.cmp1Match | ctrl[OBC_CMP1_LSB])
            & (~events.overUnder | ctrl[OBC_OVF_LSB]); // RQ2
        // decode the merged action
        case ({bit0, bit1})
            2'b00: state_d.pin = 1'b1; // RQ3
            2'b01: state_d.pin = ~state_q.pin; // RQ3
            2'b10: state_d.pin = 1'b0; // RQ3
            default: state_d.pin = state_q.pin; // RQ3
        endcase
        // software preset overrides the event action
        if (presetWr) begin
            state_d.pin = presetVal; // RQ1
        end
        // one-cycle on-chip pulse per over/underflow
        state_d.pulse = events.overUnder & ctrl[OBC_EVENT_BIT]; // RQ5
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_q <= '0;
        end else if (clkEn) begin
            state_q <= state_d;
        end
    end

    assign pinLevel = state_q.pin;
    assign eventPulse = state_q.pulse & clkEn;
endmodule : tedc_outb

// >>> tedc_vector.sv
// interrupt vector register with hardware group code
module tedc_vector
    import tedc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clkEn,
    input wire logic wrEn,
    input wire logic [7:0] wrData,
    input wire logic ovfReq,
    input wire logic capReq,
    input wire logic cmpReq,
    output logic [7:0] vector
);
    // all state of the module
    typedef struct packed {
        logic [4:0] base;
        logic [1:0] group;
    } tedc_vec_s;

    tedc_vec_s state_q;
    tedc_vec_s state_d;

    // next state: software base, hardware group by highest request
    always_comb begin
        state_d = state_q;
        if (wrEn) begin
            state_d.base = wrData[7:3]; // RQ20
        end
        // overflow first, then capture, then compare
        if (ovfReq) begin
            state_d.group = GRP_OVERFLOW; // RQ21
        end else if (capReq) begin
            state_d.group = GRP_CAPTURE; // RQ21
        end else if (cmpReq) begin
            state_d.group = GRP_COMPARE; // RQ21
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_q <= tedc_vec_s'(RST_VECTOR[6:0]);
        end else if (clkEn) begin
            state_q <= state_d;
        end
    end

    // bit 0 always reads zero
    assign vector = {state_q.base, state_q.group, 1'b0}; // RQ20
endmodule : tedc_vector

// >>> tedc_control.sv
// flags, masks, dma pointers and register access for the timer event section
// Operation
// RQ1: preset bit writes level, read shows pin
// RQ2: three two-bit output-b action fields
// RQ3: codes: set, toggle, reset, no operation
// RQ4: coinciding events AND their action bits
// RQ5: over/underflow pulse when event enable set
// RQ6: capture0 flag set by hardware; software simulates
// RQ7: capture1 flag, software capture except bicapture
// RQ8: compare flags interrupt via global and mask
// RQ9: over/underflow flag interrupt via global, mask
// RQ10: capture0 overrun on repeat or software set
// RQ11: compare0 overrun on repeated request
// RQ12: combine bit selects OR or AND captures
// RQ13: global enable gates every timer interrupt
// RQ14: capture0 dma mask, hardware clears, eob interrupt
// RQ15: compare0 dma mask, hardware clears, eob interrupt
// RQ16: counter pointer upper bits, swap toggles bit
// RQ17: direction bit by hardware, bit0 area select
// RQ18: address pointer upper bits, swap toggles bit
// RQ19: extension select picks segment register
// RQ20: vector base five bits, bit0 zero
// RQ21: group codes 00, 10, 11
// RQ22: write zero clears flags
module tedc_control
    import tedc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clkEn,
    input wire tedc_regacc_s regAcc,
    output logic [7:0] rdData,
    input wire tedc_events_s events,
    input wire tedc_dma_s dma,
    input wire logic bicaptureMode,
    output logic timerOutputBPin,
    output logic onChipEvent,
    output logic swCapture0,
    output logic swCapture1,
    output logic irqRequest,
    output logic cap0DmaEnable,
    output logic cmp0DmaEnable,
    output logic dmaRegisterFile,
    output logic useDmaSegment,
    output logic [7:0] dmaCounterPointer,
    output logic [7:0] dmaAddressPointer
);
    // all state of the module
    typedef struct packed {
        logic [7:0] obc;
        logic [7:0] flags;
        logic [7:0] mask;
        logic [7:0] cntPtr;
        logic [7:0] adrPtr;
        logic swCap0;
        logic swCap1;
        logic [7:0] rd;
    } tedc_ctl_s;

    tedc_ctl_s state_q;
    tedc_ctl_s state_d;
    logic [7:0] vector; // vector register contents
    logic pinLevel; // current output-b level
    logic eventPulse; // on-chip event pulse
    logic wrObc; // write strobes per register
    logic wrFlags;
    logic wrMask;
    logic wrVec;
    logic cap0Src; // combined source terms
    logic cap1Src;
    logic capIrq; // per-group requests
    logic cmpIrq;
    logic ovfIrq;
    logic cap0Event; // effective capture events
    logic cap1Event;

    // address match used for every register
    function automatic logic hit(input tedc_regacc_s acc, input logic [7:0] a);
        hit = acc.wrEn && (acc.addr == a);
    endfunction : hit

    assign wrObc = hit(regAcc, ADDR_OUTPUT_B_CONTROL);
    assign wrFlags = hit(regAcc, ADDR_TIMER_EVENT_FLAGS);
    assign wrMask = hit(regAcc, ADDR_INTERRUPT_DMA_MASK);
    assign wrVec = hit(regAcc, ADDR_TIMER_INTERRUPT_VECTOR);

    // software set of a capture flag counts as a capture
    assign cap0Event = events.capture0 | state_q.swCap0; // RQ6
    assign cap1Event = events.capture1 | (state_q.swCap1 & ~bicaptureMode); // RQ7

    // capture interrupt sources; dma mode raises end of block instead
    assign cap0Src = state_q.mask[MSK_CAP0_IRQ] & (state_q.mask[MSK_CAP0_DMA]
        ? dma.cap0EndOfBlock : state_q.flags[FLG_CAP0]); // RQ14
    assign cap1Src = state_q.mask[MSK_CAP1_IRQ] & state_q.flags[FLG_CAP1];
    assign capIrq = state_q.flags[FLG_COMBINE] ? (cap0Src & cap1Src)
        : (cap0Src | cap1Src); // RQ12
    assign cmpIrq = (state_q.mask[MSK_CMP0_IRQ] & (state_q.mask[MSK_CMP0_DMA]
        ? dma.cmp0EndOfBlock : state_q.flags[FLG_CMP0]))
        | (state_q.mask[MSK_CMP1_IRQ] & state_q.flags[FLG_CMP1]); // RQ15 RQ8
    assign ovfIrq = state_q.mask[MSK_OVF_IRQ] & state_q.flags[FLG_OVF]; // RQ9
    // global enable gates all groups
    assign irqRequest = state_q.mask[MSK_GLOBAL] & (capIrq | cmpIrq | ovfIrq); // RQ13

    // next state of flags, masks, pointers and read data
    always_comb begin
        state_d = state_q;
        state_d.swCap0 = 1'b0;
        state_d.swCap1 = 1'b0;
        // output-b control register
        if (wrObc) begin
            state_d.obc = regAcc.wrData;
        end
        // flag register write: zero clears, one on captures simulates
        if (wrFlags) begin
            state_d.flags = state_q.flags & regAcc.wrData; // RQ22
            state_d.flags[FLG_COMBINE] = regAcc.wrData[FLG_COMBINE]; // RQ12
            if (regAcc.wrData[FLG_CAP0] && !state_q.flags[FLG_CAP0]) begin
                state_d.swCap0 = 1'b1; // RQ6
                state_d.flags[FLG_CAP0_OVR] = 1'b1; // RQ10
            end
            if (regAcc.wrData[FLG_CAP1] && !state_q.flags[FLG_CAP1] && !bicaptureMode) begin
                state_d.swCap1 = 1'b1; // RQ7
            end
        end
        // hardware sets win over software clears
        state_d.flags[FLG_CAP0] |= cap0Event; // RQ6
        state_d.flags[FLG_CAP1] |= cap1Event; // RQ7
        state_d.flags[FLG_CMP0] |= events.cmp0Match; // RQ8
        state_d.flags[FLG_CMP1] |= events.cmp1Match; // RQ8
        state_d.flags[FLG_OVF] |= events.overUnder; // RQ9
        // overrun: new request while flag still pending
        if ((cap0Event || dma.cap0Request) && state_q.flags[FLG_CAP0]) begin
            state_d.flags[FLG_CAP0_OVR] = 1'b1; // RQ10
        end
        if ((events.cmp0Match || dma.cmp0Request) && state_q.flags[FLG_CMP0]) begin
            state_d.flags[FLG_CMP0_OVR] = 1'b1; // RQ11
        end
        // mask register; dma enables cleared by hardware at end of block
        if (wrMask) begin
            state_d.mask = regAcc.wrData;
        end
        state_d.mask[MSK_CAP0_DMA] &= ~dma.cap0EndOfBlock; // RQ14
        state_d.mask[MSK_CMP0_DMA] &= ~dma.cmp0EndOfBlock; // RQ15
        // pointers: software writes all but the direction bit
        if (hit(regAcc, ADDR_DMA_COUNTER_POINTER)) begin
            state_d.cntPtr[7:2] = regAcc.wrData[7:2]; // RQ16
            state_d.cntPtr[PTR_SEL_BIT] = regAcc.wrData[PTR_SEL_BIT]; // RQ17
        end
        if (hit(regAcc, ADDR_DMA_ADDRESS_POINTER)) begin
            state_d.adrPtr[7:2] = regAcc.wrData[7:2]; // RQ18
            state_d.adrPtr[PTR_SEL_BIT] = regAcc.wrData[PTR_SEL_BIT]; // RQ19
        end
        // swap mode toggles pointer bit 2 on both pointers
        if (dma.swapToggle && state_q.mask[MSK_CMP0_DMA]) begin
            state_d.cntPtr[PTR_SWAP_BIT] = ~state_q.cntPtr[PTR_SWAP_BIT]; // RQ16
            state_d.adrPtr[PTR_SWAP_BIT] = ~state_q.adrPtr[PTR_SWAP_BIT]; // RQ18
        end
        // direction follows the requesting channel
        if (dma.cmp0Request || dma.cap0Request) begin
            state_d.cntPtr[PTR_DIR_BIT] = dma.cmp0Request; // RQ17
            state_d.adrPtr[PTR_DIR_BIT] = dma.cmp0Request;
        end
        // registered read data
        case (regAcc.addr)
            ADDR_DMA_COUNTER_POINTER: state_d.rd = state_q.cntPtr;
            ADDR_DMA_ADDRESS_POINTER: state_d.rd = state_q.adrPtr;
            ADDR_TIMER_INTERRUPT_VECTOR: state_d.rd = vector;
            ADDR_OUTPUT_B_CONTROL: state_d.rd = {state_q.obc[7:1], pinLevel}; // RQ1
            ADDR_TIMER_EVENT_FLAGS: state_d.rd = state_q.flags;
            ADDR_INTERRUPT_DMA_MASK: state_d.rd = state_q.mask;
            default: state_d.rd = 8'h00;
        endcase
        if (!regAcc.rdEn) begin
            state_d.rd = state_q.rd;
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_q <= '{RST_OUTPUT_B_CONTROL, RST_TIMER_EVENT_FLAGS, RST_INTERRUPT_DMA_MASK,
                RST_POINTER, RST_POINTER, 1'b0, 1'b0, 8'h00};
        end else if (clkEn) begin
            state_q <= state_d;
        end
    end

    // output-b pin and on-chip event
    tedc_outb u_outb (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .clkEn(clkEn),
        .ctrl(state_q.obc),
        .presetWr(wrObc),
        .presetVal(regAcc.wrData[OBC_PRESET_BIT]),
        .events(events),
        .pinLevel(pinLevel),
        .eventPulse(eventPulse)
    );

    // vector register, group follows the active request
    tedc_vector u_vector (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .clkEn(clkEn),
        .wrEn(wrVec),
        .wrData(regAcc.wrData),
        .ovfReq(ovfIrq),
        .capReq(capIrq),
        .cmpReq(cmpIrq),
        .vector(vector)
    );

    assign rdData = state_q.rd;
    assign timerOutputBPin = pinLevel;
    assign onChipEvent = eventPulse; // RQ5
    assign swCapture0 = state_q.swCap0;
    assign swCapture1 = state_q.swCap1;
    assign cap0DmaEnable = state_q.mask[MSK_CAP0_DMA];
    assign cmp0DmaEnable = state_q.mask[MSK_CMP0_DMA];
    assign dmaRegisterFile = state_q.cntPtr[PTR_SEL_BIT]; // RQ19
    assign useDmaSegment = ~state_q.cntPtr[PTR_SEL_BIT] & state_q.adrPtr[PTR_SEL_BIT]; // RQ19
    assign dmaCounterPointer = state_q.cntPtr;
    assign dmaAddressPointer = state_q.adrPtr;
endmodule : tedc_control

// >>> tedc_control_sva.sv
// port-level assertions of the timer event block
module tedc_control_sva
    import tedc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clkEn,
    input wire tedc_regacc_s regAcc,
    input wire logic [7:0] rdData,
    input wire tedc_events_s events,
    input wire tedc_dma_s dma,
    input wire logic timerOutputBPin,
    input wire logic onChipEvent,
    input wire logic irqRequest,
    input wire logic cmp0DmaEnable,
    input wire logic dmaRegisterFile,
    input wire logic useDmaSegment,
    input wire logic [7:0] dmaCounterPointer,
    input wire logic [7:0] dmaAddressPointer
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] obc_q; // shadow of the output-b control fields
    logic glb_q; // shadow of the global interrupt enable
    logic obcWr; // software write to output_b_control this cycle
    logic [1:0] act; // merged pin action of this cycle's events
    logic rdMapped; // read lands on a mapped register

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    // write strobe, merged action and address decode
    assign obcWr = clkEn && regAcc.wrEn && (regAcc.addr == ADDR_OUTPUT_B_CONTROL);
    assign act = (events.cmp0Match ? obc_q[7:6] : 2'h3) & (events.cmp1Match ? obc_q[5:4] : 2'h3)
        & (events.overUnder ? obc_q[3:2] : 2'h3);
    assign rdMapped = regAcc.addr inside {[8'hF0:8'hF2], [8'hFD:8'hFF]};

    // shadows follow software writes only
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            obc_q <= 8'h00;
            glb_q <= 1'h0;
        end else if (obcWr) begin
            obc_q <= regAcc.wrData;
        end else if (clkEn && regAcc.wrEn && (regAcc.addr == ADDR_INTERRUPT_DMA_MASK)) begin
            glb_q <= regAcc.wrData[MSK_GLOBAL];
        end
    end

    a_rd_unmapped: assert property (clkEn && regAcc.rdEn && !rdMapped |=> rdData == 8'h00)
        else $error("unmapped read returned data");
    a_vec_lsb: assert property (
        clkEn && regAcc.rdEn && regAcc.addr == ADDR_TIMER_INTERRUPT_VECTOR |=> !rdData[0])
        else $error("vector bit 0 read as one");
    a_pin_set: assert property (clkEn && !obcWr && act == 2'h0 |=> timerOutputBPin)
        else $error("set action left pin low");
    a_pin_clear: assert property (clkEn && !obcWr && act == 2'h2 |=> !timerOutputBPin)
        else $error("reset action left pin high");
    a_pin_toggle: assert property (
        clkEn && !obcWr && act == 2'h1 |=> timerOutputBPin != $past(timerOutputBPin))
        else $error("toggle action did not invert pin");
    a_pin_hold: assert property (
        !clkEn || (!obcWr && act == 2'h3) |=> $stable(timerOutputBPin))
        else $error("pin moved without an action");
    a_event_on: assert property (clkEn && events.overUnder && obc_q[1] |=> onChipEvent)
        else $error("missing on-chip event pulse");
    a_event_off: assert property (
        !(clkEn && events.overUnder && obc_q[1]) |=> !onChipEvent)
        else $error("stray on-chip event pulse");
    a_irq_gate: assert property (!glb_q |-> !irqRequest)
        else $error("interrupt raised with global enable clear");
    a_area_sel: assert property (dmaRegisterFile == dmaCounterPointer[0]
        && useDmaSegment == (!dmaRegisterFile && dmaAddressPointer[0]))
        else $error("dma area selection mismatch");
    a_swap_bit: assert property (clkEn && dma.swapToggle && cmp0DmaEnable
        && !(regAcc.wrEn && regAcc.addr == ADDR_DMA_COUNTER_POINTER)
        |=> dmaCounterPointer[2] != $past(dmaCounterPointer[2]))
        else $error("swap did not toggle counter pointer bit");

    c_toggle: cover property (clkEn && act == 2'h1);
    c_event: cover property (onChipEvent);
    c_swap: cover property (dma.swapToggle && cmp0DmaEnable);
endmodule : tedc_control_sva

// >>> tedc_dma_model.sv
// partner model: dma requests and end-of-block pulses
module tedc_dma_model
    import tedc_pkg::*;
#(
    parameter int BLOCK_LEN = 2 // transfers per block
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic reqCap,
    input wire logic reqCmp,
    input wire logic swapMode,
    input wire logic cap0DmaEnable,
    input wire logic cmp0DmaEnable,
    output tedc_dma_s dma
);
    timeunit 1ns;
    timeprecision 100ps;
    int capCnt_q; // transfers done in the capture block
    int cmpCnt_q; // transfers done in the compare block

    // one transfer per command on an armed channel; the last one closes the block
    always_ff @(posedge sys_clk) begin
        dma <= '0;
        if (!rstn) begin
            capCnt_q <= 0;
            cmpCnt_q <= 0;
        end else begin
            if (reqCap && cap0DmaEnable) begin
                dma.cap0Request <= 1'h1;
                dma.cap0EndOfBlock <= (capCnt_q == BLOCK_LEN - 1);
                capCnt_q <= (capCnt_q == BLOCK_LEN - 1) ? 0 : capCnt_q + 1;
            end
            if (reqCmp && cmp0DmaEnable) begin
                dma.cmp0Request <= 1'h1;
                dma.cmp0EndOfBlock <= (cmpCnt_q == BLOCK_LEN - 1);
                dma.swapToggle <= swapMode && (cmpCnt_q == BLOCK_LEN - 1);
                cmpCnt_q <= (cmpCnt_q == BLOCK_LEN - 1) ? 0 : cmpCnt_q + 1;
            end
        end
    end
endmodule : tedc_dma_model

// >>> tedc_control_tb_top.sv
// bench top: register-level scenarios
module tedc_control_tb_top
    import tedc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'h0; // 100 MHz clock
    logic rstn, clkEn, bicaptureMode, reqCap, reqCmp, swapMode; // bench-driven controls
    tedc_regacc_s regAcc; // register access strobe
    tedc_events_s events; // counter datapath events
    tedc_dma_s dma; // from the dma model
    logic [7:0] rdData, dmaCounterPointer, dmaAddressPointer; // wide outputs
    logic timerOutputBPin, onChipEvent, swCapture0, swCapture1, irqRequest; // single outputs
    logic cap0DmaEnable, cmp0DmaEnable, dmaRegisterFile, useDmaSegment; // dma outputs
    int errCount = 0; // mismatches
    int nCompared = 0; // comparisons

    always #5 sys_clk = ~sys_clk;

    tedc_control tedc_control_i (.*);
    tedc_dma_model #(.BLOCK_LEN(2)) tedc_dma_model_i (.*);

    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errCount++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // verdict and end of run
    task automatic wrapUp();
        $display("comparisons %0d mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrapUp
    // step to just after the next rising edge
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask : tick
    // one-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick();
        regAcc = '{1'h1, 1'h0, a, d};
        tick();
        regAcc = '0;
    endtask : wr
    // one-cycle read, data compared under a mask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
        tick();
        regAcc = '{1'h0, 1'h1, a, 8'h00};
        tick();
        regAcc = '0;
        check(rdData & m, exp);
    endtask : rd
    // one-cycle event pulse; registered results are visible on return
    task automatic pulse(input logic [4:0] e);
        tick();
        events = tedc_events_s'(e);
        tick();
        events = '0;
    endtask : pulse
    // one dma command to the model
    task automatic req(input logic isCmp);
        tick();
        reqCmp = isCmp;
        reqCap = !isCmp;
        tick();
        reqCmp = 1'h0;
        reqCap = 1'h0;
    endtask : req
    // bounded wait for a channel mask to drop
    task automatic waitDisarm(input logic isCmp);
        int k = 0;
        while ((isCmp ? cmp0DmaEnable : cap0DmaEnable) !== 1'h0 && k < 20) begin
            tick();
            k++;
        end
        if (k == 20) begin
            errCount++;
            $display("BAD t=%0t dma channel never disarmed", $time);
            wrapUp();
        end
    endtask : waitDisarm

    // main sequence
    initial begin
        logic [7:0] ctl;
        logic [7:0] msk [3] = '{8'h81, 8'h82, 8'h90};
        logic [4:0] evt [3] = '{5'h04, 5'h08, 5'h01};
        logic [7:0] vec [3] = '{8'hF8, 8'hFE, 8'hFC};
        rstn = 1'h0;
        clkEn = 1'h1;
        bicaptureMode = 1'h0;
        reqCap = 1'h0;
        reqCmp = 1'h0;
        swapMode = 1'h1;
        regAcc = '0;
        events = '0;
        repeat (8) @(posedge sys_clk);
        #1 rstn = 1'h1;
        // reset values and an unmapped address
        rd(ADDR_OUTPUT_B_CONTROL, 8'h00, 8'hFF);
        rd(ADDR_TIMER_EVENT_FLAGS, 8'h00, 8'hFF);
        rd(ADDR_INTERRUPT_DMA_MASK, 8'h00, 8'hFF);
        rd(8'h10, 8'h00, 8'hFF);
        rd(ADDR_TIMER_INTERRUPT_VECTOR, 8'h00, 8'h01);
        // every code of every action field, others held
        for (int f = 0; f < 3; f++) begin
            for (int c = 0; c < 4; c++) begin
                ctl = 8'hFC;
                ctl[6 - 2 * f +: 2] = c[1:0];
                ctl[0] = c[1];
                wr(ADDR_OUTPUT_B_CONTROL, ctl);
                check({7'h00, timerOutputBPin}, {7'h00, ctl[0]});
                pulse(5'h10 >> f);
                check({7'h00, timerOutputBPin}, (c == 2) ? 8'h00 : 8'h01);
                rd(ADDR_OUTPUT_B_CONTROL, {ctl[7:1], c != 2}, 8'hFF);
            end
        end
        // toggle and reset together merge into set
        wr(ADDR_OUTPUT_B_CONTROL, 8'h6C);
        pulse(5'h18);
        check({7'h00, timerOutputBPin}, 8'h01);
        // on-chip event pulse enabled, then disabled
        wr(ADDR_OUTPUT_B_CONTROL, 8'hFE);
        pulse(5'h04);
        check({7'h00, onChipEvent}, 8'h01);
        tick();
        check({7'h00, onChipEvent}, 8'h00);
        wr(ADDR_OUTPUT_B_CONTROL, 8'hFC);
        pulse(5'h04);
        check({7'h00, onChipEvent}, 8'h00);
        // frozen while the clock enable is low
        wr(ADDR_TIMER_EVENT_FLAGS, 8'h00);
        clkEn = 1'h0;
        pulse(5'h04);
        clkEn = 1'h1;
        rd(ADDR_TIMER_EVENT_FLAGS, 8'h00, 8'h08);
        // all sources masked in, global enable off
        wr(ADDR_INTERRUPT_DMA_MASK, 8'h37);
        pulse(5'h1F);
        check({7'h00, irqRequest}, 8'h00);
        wr(ADDR_TIMER_EVENT_FLAGS, 8'h00);
        // second compare-0 match before clearing
        wr(ADDR_INTERRUPT_DMA_MASK, 8'h84);
        pulse(5'h10);
        pulse(5'h10);
        rd(ADDR_TIMER_EVENT_FLAGS, 8'h22, 8'hFF);
        wr(ADDR_TIMER_EVENT_FLAGS, 8'h00);
        rd(ADDR_TIMER_EVENT_FLAGS, 8'h00, 8'hFF);
        // each interrupt group with its vector code
        wr(ADDR_TIMER_INTERRUPT_VECTOR, 8'hFF);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_INTERRUPT_DMA_MASK, msk[i]);
            pulse(evt[i]);
            check({7'h00, irqRequest}, 8'h01);
            rd(ADDR_TIMER_INTERRUPT_VECTOR, vec[i], 8'hFF);
            wr(ADDR_TIMER_EVENT_FLAGS, 8'h00);
            check({7'h00, irqRequest}, 8'h00);
        end
        // capture interrupt as an and of both captures
        wr(ADDR_TIMER_EVENT_FLAGS, 8'h01);
        wr(ADDR_INTERRUPT_DMA_MASK, 8'hB0);
        pulse(5'h02);
        check({7'h00, irqRequest}, 8'h00);
        pulse(5'h01);
        check({7'h00, irqRequest}, 8'h01);
        wr(ADDR_TIMER_EVENT_FLAGS, 8'h00);
        // software-simulated captures
        wr(ADDR_INTERRUPT_DMA_MASK, 8'h00);
        wr(ADDR_TIMER_EVENT_FLAGS, 8'h80);
        check({7'h00, swCapture0}, 8'h01);
        rd(ADDR_TIMER_EVENT_FLAGS, 8'h84, 8'hFF);
        wr(ADDR_TIMER_EVENT_FLAGS, 8'h00);
        wr(ADDR_TIMER_EVENT_FLAGS, 8'h40);
        check({7'h00, swCapture1}, 8'h01);
        wr(ADDR_TIMER_EVENT_FLAGS, 8'h00);
        bicaptureMode = 1'h1;
        wr(ADDR_TIMER_EVENT_FLAGS, 8'h40);
        check({7'h00, swCapture1}, 8'h00);
        bicaptureMode = 1'h0;
        wr(ADDR_TIMER_EVENT_FLAGS, 8'h00);
        // pointers, area selection and a swapped compare block
        wr(ADDR_DMA_COUNTER_POINTER, 8'h05);
        check({7'h00, dmaRegisterFile}, 8'h01);
        wr(ADDR_DMA_ADDRESS_POINTER, 8'h09);
        check({7'h00, useDmaSegment}, 8'h00);
        wr(ADDR_DMA_COUNTER_POINTER, 8'h04);
        check({7'h00, useDmaSegment}, 8'h01);
        wr(ADDR_INTERRUPT_DMA_MASK, 8'h08);
        check({7'h00, cmp0DmaEnable}, 8'h01);
        req(1'h1);
        req(1'h1);
        waitDisarm(1'h1);
        check({7'h00, cmp0DmaEnable}, 8'h00);
        rd(ADDR_DMA_COUNTER_POINTER, 8'h02, 8'hFF);
        rd(ADDR_DMA_ADDRESS_POINTER, 8'h0F, 8'hFF);
        // capture block
        wr(ADDR_INTERRUPT_DMA_MASK, 8'h40);
        check({7'h00, cap0DmaEnable}, 8'h01);
        req(1'h0);
        req(1'h0);
        waitDisarm(1'h0);
        check({7'h00, cap0DmaEnable}, 8'h00);
        rd(ADDR_DMA_COUNTER_POINTER, 8'h00, 8'h02);
        wrapUp();
    end
endmodule : tedc_control_tb_top

bind tedc_control tedc_control_sva tedc_control_sva_i (.*);
